/* File: hdl/cdt_decode.sv */
// Purpose: Decode one opcode into class, status mask, cycle, access and time cost.
// Assumes: Requests come from same-clock logic; wait count comes from the memory side.
// Notes: Results appear one cycle after the request; events beat a request.
`timescale 1ns/1ps
module cdt_decode (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Decode request
  input wire logic req_i,
  input wire logic [15:0] opcode_i,
  input wire logic [15:0] status_i,
  input wire logic [3:0] shift_count_i,
  input wire logic operand_msb_i,
  input wire logic div_overflow_i,
  // Sequence events
  input wire logic reset_seq_i,
  input wire logic load_i,
  input wire logic intr_i,
  // Memory wait states, asynchronous
  input wire logic [3:0] wait_states_i,
  // Results
  output logic valid_o,
  output logic [3:0] op_class_o,
  output logic illegal_o,
  output logic [7:0] cycles_o,
  output logic [3:0] accesses_o,
  output logic [9:0] total_o,
  output logic [15:0] status_mask_o,
  output logic jump_taken_o,
  output logic link_r11_o
);
  logic [3:0] wait_s1_q;
  logic [3:0] wait_s2_q;
  logic any_req;
  cdt_pkg::cdt_class_t cls_d;
  logic [7:0] cyc_b;
  logic [3:0] acc_b;
  logic [7:0] cyc_d;
  logic [3:0] acc_d;
  logic [15:0] mask_d;
  logic [1:0] smod;
  logic [1:0] dmod;
  logic taken_d;
  logic link_d;
  logic [3:0] cnt;
  logic [11:0] sm;
  logic [11:0] dm;
  // Wait count is held steady by slow memory, so a level sync is enough
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_s1_q <= 4'h0;
      wait_s2_q <= 4'h0;
    end else begin
      wait_s1_q <= wait_states_i;
      wait_s2_q <= wait_s1_q;
    end
  end
  // Packs {cycles, accesses} of one operand's address mode
  function automatic logic [11:0] mod_cost(input logic [1:0] kind, input logic [1:0] t);
    logic [11:0] r;
    r = 12'h000;
    if (kind != cdt_pkg::MOD_NONE) begin
      case (t)
        2'b01: r = {cdt_pkg::C_IND, cdt_pkg::M_IND};
        2'b10: r = {cdt_pkg::C_SYM, cdt_pkg::M_SYM}; // RULE_05
        2'b11: r = (kind == cdt_pkg::MOD_BYTE) ? {cdt_pkg::C_AUTO_B, cdt_pkg::M_AUTO_B} :
                   {cdt_pkg::C_AUTO_W, cdt_pkg::M_AUTO_W}; // RULE_03 RULE_04
        default: r = 12'h000;
      endcase
    end
    return r;
  endfunction
  assign any_req = req_i | reset_seq_i | load_i | intr_i;
  assign cnt = opcode_i[9:6];
  always_comb begin
    cls_d = cdt_pkg::CL_ILLEGAL;
    cyc_b = cdt_pkg::C_ILL; // RULE_14
    acc_b = cdt_pkg::M_1;
    mask_d = cdt_pkg::MASK_NONE; // RULE_24
    smod = cdt_pkg::MOD_NONE;
    dmod = cdt_pkg::MOD_NONE;
    taken_d = 1'b0;
    link_d = 1'b0;
    if (reset_seq_i || load_i || intr_i) begin
      cls_d = cdt_pkg::CL_EVENT;
      // Reset outranks load and interrupt when they coincide
      cyc_b = reset_seq_i ? cdt_pkg::C_26 : cdt_pkg::C_22; // RULE_12 RULE_13
      acc_b = cdt_pkg::M_5;
    end else if (opcode_i[15:12] >= 4'h4) begin
      cls_d = cdt_pkg::CL_DUAL; // RULE_15
      cyc_b = cdt_pkg::C_14;
      acc_b = (opcode_i[15:13] == 3'h4) ? cdt_pkg::M_3 : cdt_pkg::M_4;
      mask_d = (opcode_i[15:13] == 3'h3 || opcode_i[15:13] == 3'h5) ?
               cdt_pkg::MASK_0_4 : cdt_pkg::MASK_0_2;
      if (opcode_i[12]) begin
        mask_d = mask_d | cdt_pkg::MASK_PAR; // RULE_15
      end
      smod = opcode_i[12] ? cdt_pkg::MOD_BYTE : cdt_pkg::MOD_WORD;
      dmod = smod;
    end else if (opcode_i[15:13] == 3'h1) begin
      smod = cdt_pkg::MOD_WORD;
      cls_d = cdt_pkg::CL_LOGIC;
      cyc_b = cdt_pkg::C_14;
      acc_b = cdt_pkg::M_3;
      case (opcode_i[12:10])
        3'h0, 3'h1: mask_d = cdt_pkg::MASK_EQ;
        3'h2: begin
          acc_b = cdt_pkg::M_4;
          mask_d = cdt_pkg::MASK_0_2;
        end
        3'h3: begin
          cyc_b = cdt_pkg::C_36;
          acc_b = cdt_pkg::M_8;
          mask_d = cdt_pkg::MASK_EXT_OP;
        end
        3'h4: begin
          cls_d = cdt_pkg::CL_SERIAL;
          cyc_b = (cnt == 4'h0) ? cdt_pkg::C_52 : 8'(cdt_pkg::C_20 + {cnt, 1'b0}); // RULE_09
        end
        3'h5: begin
          cls_d = cdt_pkg::CL_SERIAL;
          acc_b = cdt_pkg::M_4;
          cyc_b = (cnt == 4'h0) ? cdt_pkg::C_60 : (cnt < 4'h8) ? cdt_pkg::C_42 :
                  (cnt == 4'h8) ? cdt_pkg::C_44 : cdt_pkg::C_58; // RULE_10
        end
        3'h6: begin
          cls_d = cdt_pkg::CL_MULDIV;
          cyc_b = cdt_pkg::C_52; // RULE_21
          acc_b = cdt_pkg::M_5;
        end
        default: begin
          cls_d = cdt_pkg::CL_MULDIV;
          mask_d = cdt_pkg::MASK_OVF; // RULE_21
          // Worst case reported; the real figure depends on the operands
          cyc_b = div_overflow_i ? cdt_pkg::C_16 : cdt_pkg::C_DIV_MAX; // RULE_07
          acc_b = div_overflow_i ? cdt_pkg::M_3 : cdt_pkg::M_6;
        end
      endcase
      if (opcode_i[12:11] == 2'b10) begin
        mask_d = (cnt != 4'h0 && cnt <= 4'h8) ? (cdt_pkg::MASK_0_2 | cdt_pkg::MASK_PAR) :
                 cdt_pkg::MASK_0_2; // RULE_23
        smod = (cnt != 4'h0 && cnt <= 4'h8) ? cdt_pkg::MOD_BYTE : cdt_pkg::MOD_WORD;
      end
    end else if (opcode_i[15:12] == 4'h1) begin
      if (opcode_i[11:8] <= 4'hc) begin
        cls_d = cdt_pkg::CL_JUMP; // RULE_16
        case (opcode_i[11:8])
          4'h0: taken_d = 1'b1;
          4'h1: taken_d = !status_i[1] && !status_i[2];
          4'h2: taken_d = !status_i[0] || status_i[2];
          4'h3: taken_d = status_i[2];
          4'h4: taken_d = status_i[0] || status_i[2];
          4'h5: taken_d = status_i[1];
          4'h6: taken_d = !status_i[2];
          4'h7: taken_d = !status_i[3];
          4'h8: taken_d = status_i[3];
          4'h9: taken_d = !status_i[4];
          4'ha: taken_d = !status_i[0] && !status_i[2];
          4'hb: taken_d = status_i[0] && !status_i[2];
          default: taken_d = status_i[5];
        endcase
        cyc_b = taken_d ? cdt_pkg::C_10 : cdt_pkg::C_8; // RULE_08
      end else begin
        cls_d = cdt_pkg::CL_IOBIT;
        cyc_b = cdt_pkg::C_12;
        acc_b = cdt_pkg::M_2;
        mask_d = (opcode_i[11:8] == 4'hf) ? cdt_pkg::MASK_EQ : cdt_pkg::MASK_NONE;
      end
    end else if (opcode_i[15:10] == 6'h02) begin
      cls_d = cdt_pkg::CL_SHIFT; // RULE_20
      mask_d = (opcode_i[9:8] == 2'h2) ? cdt_pkg::MASK_0_4 : cdt_pkg::MASK_0_3;
      if (opcode_i[7:4] != 4'h0) begin
        cyc_b = 8'(cdt_pkg::C_12 + {opcode_i[7:4], 1'b0}); // RULE_11
        acc_b = cdt_pkg::M_3;
      end else begin
        cyc_b = (shift_count_i == 4'h0) ? cdt_pkg::C_52 :
                8'(cdt_pkg::C_20 + {shift_count_i, 1'b0}); // RULE_11
        acc_b = cdt_pkg::M_4;
      end
    end else if (opcode_i[15:10] == 6'h01 && opcode_i[9:7] != 3'h7) begin
      cls_d = cdt_pkg::CL_SINGLE;
      smod = cdt_pkg::MOD_WORD;
      cyc_b = cdt_pkg::C_10;
      acc_b = cdt_pkg::M_3;
      case (cnt)
        4'h0: begin
          cls_d = cdt_pkg::CL_BRANCH; // RULE_22
          cyc_b = cdt_pkg::C_26;
          acc_b = cdt_pkg::M_6;
        end
        4'h1, 4'h2: begin
          cls_d = cdt_pkg::CL_BRANCH;
          cyc_b = cdt_pkg::C_8;
          acc_b = cdt_pkg::M_2;
        end
        4'h4: begin
          cyc_b = cdt_pkg::C_12;
          mask_d = cdt_pkg::MASK_0_4;
        end
        4'h5: mask_d = cdt_pkg::MASK_0_2;
        4'h6, 4'h7, 4'h8, 4'h9: mask_d = cdt_pkg::MASK_0_4;
        4'ha: begin
          cls_d = cdt_pkg::CL_BRANCH;
          link_d = 1'b1; // RULE_22
          cyc_b = cdt_pkg::C_12;
        end
        4'hd: begin
          mask_d = cdt_pkg::MASK_0_4;
          cyc_b = operand_msb_i ? cdt_pkg::C_14 : cdt_pkg::C_12;
          acc_b = operand_msb_i ? cdt_pkg::M_4 : cdt_pkg::M_2;
        end
        default: mask_d = cdt_pkg::MASK_NONE;
      endcase
    end else if (opcode_i[15:8] == 8'h03 && opcode_i[7:5] != 3'h1) begin
      cls_d = cdt_pkg::CL_CTRL; // RULE_17
      cyc_b = cdt_pkg::C_12;
      if (opcode_i[7:5] == 3'h0) begin
        cls_d = cdt_pkg::CL_IMM;
        cyc_b = cdt_pkg::C_16;
        acc_b = cdt_pkg::M_2;
        mask_d = cdt_pkg::MASK_INT; // RULE_18
      end else if (opcode_i[7:5] == 3'h3 || opcode_i[7:5] == 3'h7) begin
        mask_d = cdt_pkg::MASK_INT; // RULE_17
      end else if (opcode_i[7:5] == 3'h4) begin
        cyc_b = cdt_pkg::C_14;
        acc_b = cdt_pkg::M_4;
        mask_d = cdt_pkg::MASK_RET; // RULE_19
      end
    end else if (opcode_i[15:8] == 8'h02) begin
      cls_d = cdt_pkg::CL_IMM;
      cyc_b = cdt_pkg::C_14;
      acc_b = cdt_pkg::M_4;
      mask_d = cdt_pkg::MASK_0_2;
      case (opcode_i[8:5])
        4'h0: begin
          cyc_b = cdt_pkg::C_12;
          acc_b = cdt_pkg::M_3;
        end
        4'h1: mask_d = cdt_pkg::MASK_0_4;
        4'h4: acc_b = cdt_pkg::M_3;
        4'h5, 4'h6: begin
          cyc_b = cdt_pkg::C_8;
          acc_b = cdt_pkg::M_2;
          mask_d = cdt_pkg::MASK_NONE;
        end
        4'h7: begin
          cyc_b = cdt_pkg::C_10;
          acc_b = cdt_pkg::M_2;
          mask_d = cdt_pkg::MASK_NONE; // RULE_18
        end
        default: mask_d = cdt_pkg::MASK_0_2;
      endcase
    end
    sm = mod_cost(smod, opcode_i[5:4]); // RULE_02
    dm = mod_cost(dmod, opcode_i[11:10]);
    cyc_d = 8'(cyc_b + sm[11:4] + dm[11:4]);
    acc_d = 4'(acc_b + sm[3:0] + dm[3:0]);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      op_class_o <= 4'h0;
      illegal_o <= 1'b0;
      cycles_o <= 8'h00;
      accesses_o <= 4'h0;
      total_o <= 10'h000;
      status_mask_o <= 16'h0000;
      jump_taken_o <= 1'b0;
      link_r11_o <= 1'b0;
    end else begin
      valid_o <= any_req;
      op_class_o <= cls_d;
      illegal_o <= any_req && cls_d == cdt_pkg::CL_ILLEGAL; // RULE_24
      cycles_o <= cyc_d;
      accesses_o <= acc_d;
      // Same wait count charged on every access of the instruction
      total_o <= {2'b00, cyc_d} + {2'b00, 8'(wait_s2_q) * 8'(acc_d)}; // RULE_01 RULE_06
      status_mask_o <= mask_d;
      jump_taken_o <= taken_d;
      link_r11_o <= link_d;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_plain;
    req_i && !reset_seq_i && !load_i && !intr_i;
  endsequence
  property p_valid;
    1 |=> (valid_o == $past(any_req));
  endproperty
  a_valid: assert property (p_valid) else $error("valid latency wrong"); // RULE_01
  property p_illegal;
    s_plain ##0 (opcode_i < 16'h0200) |=> illegal_o && cycles_o == 8'h06 &&
      accesses_o == 4'h1 && status_mask_o == 16'h0000;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal cost wrong"); // RULE_14
  property p_total;
    valid_o |-> total_o == {2'b00, cycles_o} + {2'b00, 8'($past(wait_s2_q)) * 8'(accesses_o)};
  endproperty
  a_total: assert property (p_total) else $error("total time wrong"); // RULE_01
  property p_jump;
    s_plain ##0 (opcode_i[15:8] == 8'h13) |=>
      (cycles_o == ($past(status_i[2]) ? 8'h0a : 8'h08)) && accesses_o == 4'h1 &&
      jump_taken_o == $past(status_i[2]) && status_mask_o == 16'h0000;
  endproperty
  a_jump: assert property (p_jump) else $error("jump cost wrong"); // RULE_08
  property p_mul;
    s_plain ##0 (opcode_i[15:10] == 6'h0e && opcode_i[5:4] == 2'b00) |=>
      cycles_o == 8'h34 && accesses_o == 4'h5 && status_mask_o == 16'h0000;
  endproperty
  a_mul: assert property (p_mul) else $error("multiply cost wrong"); // RULE_21
  property p_reset;
    reset_seq_i |=> cycles_o == 8'h1a && accesses_o == 4'h5 && valid_o;
  endproperty
  a_reset: assert property (p_reset) else $error("reset sequence cost wrong"); // RULE_12
  property p_shift;
    s_plain ##0 (opcode_i[15:10] == 6'h02 && opcode_i[7:4] != 4'h0) |=>
      cycles_o == 8'(8'h0c + {$past(opcode_i[7:4]), 1'b0}) && accesses_o == 4'h3;
  endproperty
  a_shift: assert property (p_shift) else $error("shift cost wrong"); // RULE_11
  property p_div_ovf;
    s_plain ##0 (opcode_i[15:10] == 6'h0f && opcode_i[5:4] == 2'b00 && div_overflow_i) |=>
      cycles_o == 8'h10 && accesses_o == 4'h3 && status_mask_o == 16'h0010;
  endproperty
  a_div_ovf: assert property (p_div_ovf) else $error("divide overflow cost wrong"); // RULE_07
  property p_autoinc;
    s_plain ##0 (opcode_i[15:12] == 4'ha && opcode_i[11:10] == 2'b00 &&
      opcode_i[5:4] == 2'b11) |=> cycles_o == 8'h16 && accesses_o == 4'h6;
  endproperty
  a_autoinc: assert property (p_autoinc) else $error("auto-increment cost wrong"); // RULE_03
  property p_mask_load;
    s_plain ##0 (opcode_i == 16'h0300) |=> status_mask_o == 16'hf000 && cycles_o == 8'h10;
  endproperty
  a_mask_load: assert property (p_mask_load) else $error("mask load wrong"); // RULE_18
endmodule

/* File: hdl/cdt_pkg.sv */
// Purpose: Constants and types for the opcode decode and timing block.
// Assumes: Status mask bit n stands for status bit n (bit 0 is the first status bit).
// Notes: Cycle and access figures below are the base costs with direct register operands.
// Notes on behaviour
// RULE_01: Total time equals cycles plus wait states times memory accesses.
// RULE_02: Base figures assume direct register operands; other modes add their own cost.
// RULE_03: Word auto-increment indirect operand adds 8 cycles and 2 accesses.
// RULE_04: Byte auto-increment indirect operand adds 6 cycles and 1 access.
// RULE_05: Symbolic or indexed operand adds 8 cycles and 1 access, word or byte.
// RULE_06: Memory asks wait states only when slow; same count added to every access.
// RULE_07: Divide costs 16 cycles, 3 accesses on overflow, else 92-124 cycles, 6.
// RULE_08: Jumps cost 10 cycles when taken, 8 when not, one access.
// RULE_09: Serial multi-load costs 52 cycles at count zero, else 20 plus 2 per bit.
// RULE_10: Serial multi-store costs 60, 42, 44 or 58 cycles by count, four accesses.
// RULE_11: Shift costs 12 plus 2 per position; register count form 52 or 20 plus 2n.
// RULE_12: Reset sequence costs 26 cycles and 5 accesses.
// RULE_13: Interrupt context switch and load sequence cost 22 cycles, 5 accesses.
// RULE_14: Undefined opcode ranges are illegal and cost 6 cycles, one access.
// RULE_15: Dual-operand ops decode by top nibble; byte forms add the parity bit.
// RULE_16: Jumps decode by upper byte in 1000 to 1C00 and change no status.
// RULE_17: External control ops decoded; reset-outputs and restart-load touch mask bits.
// RULE_18: Load mask immediate touches bits 12-15 only; load context pointer touches none.
// RULE_19: Return from context updates status bits 0-6 and 12-15.
// RULE_20: Right shifts update status 0-3; left shift updates status 0-4.
// RULE_21: Multiply touches no status, 52 cycles, 5 accesses; divide only overflow.
// RULE_22: Branch ops decoded; branch-and-link saves return address in register eleven.
// RULE_23: Serial multi-load and store compare to zero, update bits 0-2 plus parity; code adds parity only for counts 1-8.
// RULE_24: Illegal opcode only fetches, changes nothing, continues sequentially.
package cdt_pkg;
  typedef enum logic [3:0] {
    CL_ILLEGAL = 4'h0, CL_DUAL = 4'h1, CL_SINGLE = 4'h2, CL_IMM = 4'h3,
    CL_JUMP = 4'h4, CL_SHIFT = 4'h5, CL_SERIAL = 4'h6, CL_MULDIV = 4'h7,
    CL_CTRL = 4'h8, CL_BRANCH = 4'h9, CL_IOBIT = 4'ha, CL_EVENT = 4'hb,
    CL_LOGIC = 4'hc
  } cdt_class_t;
  localparam logic [1:0] MOD_NONE = 2'h0;
  localparam logic [1:0] MOD_WORD = 2'h1;
  localparam logic [1:0] MOD_BYTE = 2'h2;
  localparam logic [7:0] C_IND = 8'h04;
  localparam logic [3:0] M_IND = 4'h1;
  localparam logic [7:0] C_AUTO_W = 8'h08;
  localparam logic [3:0] M_AUTO_W = 4'h2;
  localparam logic [7:0] C_AUTO_B = 8'h06;
  localparam logic [3:0] M_AUTO_B = 4'h1;
  localparam logic [7:0] C_SYM = 8'h08;
  localparam logic [3:0] M_SYM = 4'h1;
  localparam logic [7:0] C_ILL = 8'h06;
  localparam logic [7:0] C_8 = 8'h08;
  localparam logic [7:0] C_10 = 8'h0a;
  localparam logic [7:0] C_12 = 8'h0c;
  localparam logic [7:0] C_14 = 8'h0e;
  localparam logic [7:0] C_16 = 8'h10;
  localparam logic [7:0] C_20 = 8'h14;
  localparam logic [7:0] C_22 = 8'h16;
  localparam logic [7:0] C_26 = 8'h1a;
  localparam logic [7:0] C_36 = 8'h24;
  localparam logic [7:0] C_42 = 8'h2a;
  localparam logic [7:0] C_44 = 8'h2c;
  localparam logic [7:0] C_52 = 8'h34;
  localparam logic [7:0] C_58 = 8'h3a;
  localparam logic [7:0] C_60 = 8'h3c;
  localparam logic [7:0] C_DIV_MAX = 8'h7c;
  localparam logic [3:0] M_1 = 4'h1;
  localparam logic [3:0] M_2 = 4'h2;
  localparam logic [3:0] M_3 = 4'h3;
  localparam logic [3:0] M_4 = 4'h4;
  localparam logic [3:0] M_5 = 4'h5;
  localparam logic [3:0] M_6 = 4'h6;
  localparam logic [3:0] M_8 = 4'h8;
  localparam logic [15:0] MASK_NONE = 16'h0000;
  localparam logic [15:0] MASK_0_2 = 16'h0007;
  localparam logic [15:0] MASK_0_3 = 16'h000f;
  localparam logic [15:0] MASK_0_4 = 16'h001f;
  localparam logic [15:0] MASK_EQ = 16'h0004;
  localparam logic [15:0] MASK_OVF = 16'h0010;
  localparam logic [15:0] MASK_PAR = 16'h0020;
  localparam logic [15:0] MASK_EXT_OP = 16'h0040;
  localparam logic [15:0] MASK_INT = 16'hf000;
  localparam logic [15:0] MASK_RET = 16'hf07f;
endpackage

/* File: sim/cdt_mem_model.sv */
// Purpose: Memory-side model that reports the wait states per access.
// Assumes: The wait count only changes while no decode is pending.
// Notes: Fast memory asks for none, so the count drops to zero.
`timescale 1ns/1ps
module cdt_mem_model (
  // Clock
  input wire logic clk_i,
  // Speed setting
  input wire logic slow_i,
  input wire logic [3:0] wait_set_i,
  // Wait states to the decoder
  output logic [3:0] wait_states_o
);
  // Only slow memory stretches its accesses; one count serves every access
  always_ff @(posedge clk_i) begin
    wait_states_o <= slow_i ? wait_set_i : 4'h0;
  end
endmodule

/* File: sim/cdt_decode_tb.sv */
// Purpose: Self-checking bench for the opcode decode and timing block.
// Assumes: Wait count is held at least four cycles before any request.
// Notes: Inputs change on the falling edge; results are read one cycle later.
`timescale 1ns/1ps
module cdt_decode_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req_i = 1'b0;
  logic [15:0] opcode_i = 16'h0000;
  logic [15:0] status_i = 16'h0000;
  logic [3:0] shift_count_i = 4'h0;
  logic operand_msb_i = 1'b0;
  logic div_overflow_i = 1'b0;
  logic reset_seq_i = 1'b0;
  logic load_i = 1'b0;
  logic intr_i = 1'b0;
  logic slow_i = 1'b0;
  logic [3:0] wait_set_i = 4'h0;
  logic [3:0] wait_states_i;
  logic valid_o;
  logic [3:0] op_class_o;
  logic illegal_o;
  logic [7:0] cycles_o;
  logic [3:0] accesses_o;
  logic [9:0] total_o;
  logic [15:0] status_mask_o;
  logic jump_taken_o;
  logic link_r11_o;
  int err_total = 0;
  int n_compared = 0;
  int cyc_n = 0;
  logic [3:0] w_exp = 4'h0;

  always #20 clk_i = ~clk_i;

  cdt_mem_model cdt_mem_model_inst (
    .clk_i(clk_i), .slow_i(slow_i), .wait_set_i(wait_set_i), .wait_states_o(wait_states_i)
  );

  cdt_decode cdt_decode_inst (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .opcode_i(opcode_i),
    .status_i(status_i), .shift_count_i(shift_count_i), .operand_msb_i(operand_msb_i),
    .div_overflow_i(div_overflow_i), .reset_seq_i(reset_seq_i), .load_i(load_i),
    .intr_i(intr_i), .wait_states_i(wait_states_i), .valid_o(valid_o),
    .op_class_o(op_class_o), .illegal_o(illegal_o), .cycles_o(cycles_o),
    .accesses_o(accesses_o), .total_o(total_o), .status_mask_o(status_mask_o),
    .jump_taken_o(jump_taken_o), .link_r11_o(link_r11_o)
  );

  task automatic end_of_test;
    if (err_total == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // A hang shows up as a run far longer than the scenarios need
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk(input logic [7:0] c, input logic [3:0] m, input logic [15:0] mk,
                     input logic [3:0] cls, input logic ill);
    cmp("valid", 16'h0001, {15'h0000, valid_o});
    cmp("illegal", {15'h0000, ill}, {15'h0000, illegal_o});
    cmp("cycles", {8'h00, c}, {8'h00, cycles_o});
    cmp("accesses", {12'h000, m}, {12'h000, accesses_o});
    cmp("total", 16'(c) + 16'(w_exp) * 16'(m), {6'h00, total_o});
    cmp("mask", mk, status_mask_o);
    // Class codes are only pinned down for a few groups
    if (cls != 4'hf) begin
      cmp("class", {12'h000, cls}, {12'h000, op_class_o});
    end
  endtask

  task automatic t(input logic [15:0] code, input logic [7:0] c, input logic [3:0] m,
                   input logic [15:0] mk, input logic [3:0] cls = 4'hf,
                   input logic ill = 1'b0);
    @(negedge clk_i);
    req_i = 1'b1;
    opcode_i = code;
    @(negedge clk_i);
    req_i = 1'b0;
    chk(c, m, mk, cls, ill);
  endtask

  task automatic setw(input logic [3:0] w);
    @(negedge clk_i);
    slow_i = (w != 4'h0);
    wait_set_i = w;
    w_exp = w;
    repeat (5) @(negedge clk_i);
  endtask

  // A request beside an event must lose to it
  task automatic ev(input int k, input logic [7:0] c);
    @(negedge clk_i);
    reset_seq_i = (k == 0);
    load_i = (k == 1);
    intr_i = (k == 2);
    req_i = 1'b1;
    opcode_i = 16'hd000;
    @(negedge clk_i);
    {reset_seq_i, load_i, intr_i, req_i} = 4'h0;
    chk(c, 4'h5, 16'h0000, cdt_pkg::CL_EVENT, 1'b0);
  endtask

  task automatic s_dual;
    setw(4'h0);
    t(16'ha000, 8'h0e, 4'h4, 16'h001f, cdt_pkg::CL_DUAL);
    t(16'hb000, 8'h0e, 4'h4, 16'h003f, cdt_pkg::CL_DUAL);
    t(16'he000, 8'h0e, 4'h4, 16'h0007, cdt_pkg::CL_DUAL);
    t(16'hf000, 8'h0e, 4'h4, 16'h0027, cdt_pkg::CL_DUAL);
    setw(4'h2);
    t(16'hd000, 8'h0e, 4'h4, 16'h0027, cdt_pkg::CL_DUAL);
    t(16'ha010, 8'h12, 4'h5, 16'h001f);
    t(16'hc030, 8'h16, 4'h6, 16'h0007);
    t(16'hdc30, 8'h1a, 4'h6, 16'h0027);
    t(16'hc020, 8'h16, 4'h5, 16'h0007);
    t(16'hd821, 8'h1e, 4'h6, 16'h0027);
  endtask

  task automatic s_b2b;
    @(negedge clk_i);
    req_i = 1'b1;
    opcode_i = 16'ha000;
    @(negedge clk_i);
    opcode_i = 16'hb000;
    chk(8'h0e, 4'h4, 16'h001f, cdt_pkg::CL_DUAL, 1'b0);
    @(negedge clk_i);
    req_i = 1'b0;
    chk(8'h0e, 4'h4, 16'h003f, cdt_pkg::CL_DUAL, 1'b0);
    @(negedge clk_i);
    cmp("valid idle", 16'h0000, {15'h0000, valid_o});
  endtask

  task automatic s_jump;
    setw(4'h1);
    status_i = 16'h0000;
    t(16'h1000, 8'h0a, 4'h1, 16'h0000, cdt_pkg::CL_JUMP);
    cmp("taken", 16'h0001, {15'h0000, jump_taken_o});
    t(16'h1300, 8'h08, 4'h1, 16'h0000, cdt_pkg::CL_JUMP);
    cmp("taken", 16'h0000, {15'h0000, jump_taken_o});
    t(16'h1600, 8'h0a, 4'h1, 16'h0000, cdt_pkg::CL_JUMP);
    status_i = 16'h0004;
    t(16'h1300, 8'h0a, 4'h1, 16'h0000, cdt_pkg::CL_JUMP);
    t(16'h1600, 8'h08, 4'h1, 16'h0000, cdt_pkg::CL_JUMP);
    status_i = 16'h0000;
  endtask

  task automatic s_illegal;
    logic [15:0] codes [7] = '{16'h0000, 16'h01ff, 16'h0320, 16'h0780, 16'h07ff,
                               16'h0c00, 16'h0fff};
    foreach (codes[i]) begin
      t(codes[i], 8'h06, 4'h1, 16'h0000, cdt_pkg::CL_ILLEGAL, 1'b1);
    end
  endtask

  task automatic s_serial;
    setw(4'h3);
    t(16'h3000, 8'h34, 4'h3, 16'h0007);
    t(16'h30c0, 8'h1a, 4'h3, 16'h0027);
    t(16'h33c0, 8'h32, 4'h3, 16'h0007);
    t(16'h3400, 8'h3c, 4'h4, 16'h0007);
    t(16'h35c0, 8'h2a, 4'h4, 16'h0027);
    t(16'h3600, 8'h2c, 4'h4, 16'h0027);
    t(16'h3640, 8'h3a, 4'h4, 16'h0007);
  endtask

  task automatic s_shift;
    t(16'h0830, 8'h12, 4'h3, 16'h000f);
    t(16'h0930, 8'h12, 4'h3, 16'h000f);
    t(16'h0b30, 8'h12, 4'h3, 16'h000f);
    t(16'h0af0, 8'h2a, 4'h3, 16'h001f);
    shift_count_i = 4'h0;
    t(16'h0800, 8'h34, 4'h4, 16'h000f);
    shift_count_i = 4'h5;
    t(16'h0900, 8'h1e, 4'h4, 16'h000f);
  endtask

  task automatic s_misc;
    t(16'h3800, 8'h34, 4'h5, 16'h0000);
    div_overflow_i = 1'b1;
    t(16'h3c00, 8'h10, 4'h3, 16'h0010);
    div_overflow_i = 1'b0;
    t(16'h3c00, 8'h7c, 4'h6, 16'h0010);
    t(16'h0740, 8'h0c, 4'h2, 16'h001f);
    operand_msb_i = 1'b1;
    t(16'h0740, 8'h0e, 4'h4, 16'h001f);
    operand_msb_i = 1'b0;
    t(16'h2c00, 8'h24, 4'h8, 16'h0040);
    t(16'h0220, 8'h0e, 4'h4, 16'h001f, cdt_pkg::CL_IMM);
    t(16'h0340, 8'h0c, 4'h1, 16'h0000, cdt_pkg::CL_CTRL);
    t(16'h0360, 8'h0c, 4'h1, 16'hf000);
    t(16'h03a0, 8'h0c, 4'h1, 16'h0000);
    t(16'h03c0, 8'h0c, 4'h1, 16'h0000);
    t(16'h03e0, 8'h0c, 4'h1, 16'hf000);
    t(16'h0300, 8'h10, 4'h2, 16'hf000, cdt_pkg::CL_IMM);
    t(16'h02e0, 8'h0a, 4'h2, 16'h0000);
    t(16'h0380, 8'h0e, 4'h4, 16'hf07f);
    t(16'h0400, 8'h1a, 4'h6, 16'h0000);
    t(16'h0440, 8'h08, 4'h2, 16'h0000);
    t(16'h0480, 8'h08, 4'h2, 16'h0000);
    cmp("link", 16'h0000, {15'h0000, link_r11_o});
    t(16'h0680, 8'h0c, 4'h3, 16'h0000);
    cmp("link", 16'h0001, {15'h0000, link_r11_o});
  endtask

  initial begin
    repeat (16) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    s_dual();
    s_b2b();
    s_jump();
    s_illegal();
    ev(0, 8'h1a);
    ev(1, 8'h16);
    ev(2, 8'h16);
    s_serial();
    s_shift();
    s_misc();
    end_of_test();
  end
endmodule
